/* File: rtl/ext_hop_pkg.sv */
// types shared by the rear-panel hop and trigger control block
package ext_hop_pkg;
  // hop address source selected by the hop controller
  typedef enum logic [1:0] {
    SRC_EXT = 2'b01,
    SRC_SEQ = 2'b10
  } addr_source_t;

  // burst type definition number
  typedef logic [1:0] burst_num_t;
endpackage : ext_hop_pkg

/* File: rtl/ext_hop_regs.svh */
// constants for the rear-panel hop and trigger control block
`ifndef EXT_HOP_REGS_SVH
`define EXT_HOP_REGS_SVH

// ----------------------------------------------------------------
// hop address and reset values
// ----------------------------------------------------------------
`define HOP_ADDR_BITS   11
`define HOP_ADDR_RESET  11'h000
`define BURST_RESET     2'h0

// ----------------------------------------------------------------
// control pin positions above the address lines in the sync vector
// ----------------------------------------------------------------
`define CTRL_BITS       9
`define GEN_TRIG_OFS    0
`define ANA_TRIG_OFS    1
`define SEQ_TRIG_OFS    2
`define SEQ_RST_N_OFS   3
`define SUPPRESS_N_OFS  4
`define CNT_RST_N_OFS   5
`define DEMOD_TRIG_OFS  6
`define BURST_LSB_OFS   7
`define BURST_MSB_OFS   8
// idle level of the control pins: active-low inputs rest high
`define CTRL_IDLE       9'h038

`endif

/* File: rtl/ext_hop_trigger_control.sv */
// rear-panel hop, burst select, demod trigger and counter halt control
// Operation
// - take burst type anew for every burst
// - burst number decoded with upper line as msb
// - burst lines act only when selection external
// - demod trigger honoured only for external source
// - start on rising demod trigger edge only
// - counter reset low halts and resets counters
// - halt status low while counters halted
// - halt status low always in settable mode
// - eleven address lines, unsigned, high means one
// - generator trigger edge latches address, retunes generator
// - analyzer trigger edge latches address, retunes analyzer
// - sequential mode samples address on sequence edge while sequence reset is low
// - sequential address lines load internal register only; here the load edge also retunes armed generator/analyzer
// - sequence reset acts only at next sequence edge
// - suppress input blocks sequence-triggered retune only, sequence still advances
`include "ext_hop_regs.svh"
module ext_hop_trigger_control #(
  parameter int ADDR_W = `HOP_ADDR_BITS
) (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       rstn,
  // rear-panel pins
  input  wire logic [ADDR_W-1:0]          hop_table_address,
  input  wire logic                       generator_hop_trigger,
  input  wire logic                       analyzer_hop_trigger,
  input  wire logic                       sequence_hop_trigger,
  input  wire logic                       sequence_address_reset_n,
  input  wire logic                       hop_suppress_n,
  input  wire logic                       counter_reset_in_n,
  input  wire logic                       ext_demodulation_trigger,
  input  wire logic                       burst_select_lsb,
  input  wire logic                       burst_select_msb,
  output wire logic                       counter_halt_status_n,
  // hop controller settings
  input  wire ext_hop_pkg::addr_source_t  address_source,
  input  wire logic                       generator_hop_mode,
  input  wire logic                       generator_trigger_armed,
  input  wire logic                       analyzer_hop_mode,
  input  wire logic                       analyzer_trigger_armed,
  // demodulation and measurement settings
  input  wire logic                       demod_burst_external,
  input  wire logic                       meas_burst_external,
  input  wire ext_hop_pkg::burst_num_t    demod_burst_internal,
  input  wire ext_hop_pkg::burst_num_t    meas_burst_internal,
  input  wire logic                       demod_trigger_external,
  input  wire logic                       meas_trigger_external,
  input  wire logic                       burst_start,
  input  wire logic                       settable_mode,
  // results to the generator, analyzer and dsp
  output wire logic                       generator_retune,
  output wire logic [ADDR_W-1:0]          generator_hop_address,
  output wire logic                       analyzer_retune,
  output wire logic [ADDR_W-1:0]          analyzer_hop_address,
  output wire logic [ADDR_W-1:0]          sequence_address,
  output wire ext_hop_pkg::burst_num_t    demod_burst_number,
  output wire ext_hop_pkg::burst_num_t    meas_burst_number,
  output wire logic                       demod_start,
  output wire logic                       meas_start,
  output wire logic                       counter_hold
);
  import ext_hop_pkg::*;

  localparam int SW = ADDR_W + `CTRL_BITS;
  localparam logic [SW-1:0] IDLE = {`CTRL_IDLE, {ADDR_W{1'b0}}};

  if (ADDR_W < 1 || ADDR_W > 16) begin : g_chk
    $error("hop address width must lie between 1 and 16");
  end

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  pin_sync_if #(.W(SW)) pins ();

  // address and triggers share one path so that they line up in time
  assign pins.raw = {burst_select_msb, burst_select_lsb, ext_demodulation_trigger,
                     counter_reset_in_n, hop_suppress_n, sequence_address_reset_n,
                     sequence_hop_trigger, analyzer_hop_trigger, generator_hop_trigger,
                     hop_table_address};

  pin_sync #(.W(SW), .IDLE(IDLE)) u_sync (
    .clock (clock),
    .rstn  (rstn),
    .pins  (pins)
  );

  logic [ADDR_W-1:0]     addr_c;
  logic [`CTRL_BITS-1:0] ctrl_c;
  assign addr_c = pins.clean[ADDR_W-1:0];
  assign ctrl_c = pins.clean[SW-1:ADDR_W];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [`CTRL_BITS-1:0] prev_reg, prev_next;
  logic [ADDR_W-1:0]     gen_addr_reg, gen_addr_next;
  logic [ADDR_W-1:0]     ana_addr_reg, ana_addr_next;
  logic [ADDR_W-1:0]     seq_addr_reg, seq_addr_next;
  logic                  gen_retune_reg, gen_retune_next;
  logic                  ana_retune_reg, ana_retune_next;
  burst_num_t            dburst_reg, dburst_next;
  burst_num_t            mburst_reg, mburst_next;
  logic                  dstart_reg, dstart_next;
  logic                  mstart_reg, mstart_next;
  logic                  hold_reg, hold_next;
  logic                  status_n_reg, status_n_next;

  logic [`CTRL_BITS-1:0] rise;
  logic                  gen_fire, ana_fire, seq_fire, may_retune;
  burst_num_t            burst_pins;

  // edge detection and hop decisions
  always_comb begin
    rise       = ctrl_c & ~prev_reg;
    prev_next  = ctrl_c;
    gen_fire   = rise[`GEN_TRIG_OFS] && address_source == SRC_EXT
                 && generator_hop_mode && generator_trigger_armed;
    ana_fire   = rise[`ANA_TRIG_OFS] && address_source == SRC_EXT
                 && analyzer_hop_mode && analyzer_trigger_armed;
    seq_fire   = rise[`SEQ_TRIG_OFS] && address_source == SRC_SEQ
                 && (generator_trigger_armed || analyzer_trigger_armed);
    may_retune = ctrl_c[`SUPPRESS_N_OFS];

    // reset level is only looked at on a sequence edge
    seq_addr_next = seq_addr_reg;
    if (seq_fire) begin
      if (!ctrl_c[`SEQ_RST_N_OFS]) begin
        seq_addr_next = addr_c;
      end else begin
        seq_addr_next = ADDR_W'(seq_addr_reg + 1'b1);
      end
    end

    // external addressing wins; sequence retune needs suppress released
    gen_addr_next   = gen_addr_reg;
    gen_retune_next = 1'b0;
    if (gen_fire) begin
      gen_addr_next   = addr_c;
      gen_retune_next = 1'b1;
    end else if (seq_fire && may_retune && generator_hop_mode && generator_trigger_armed) begin
      gen_addr_next   = seq_addr_next;
      gen_retune_next = 1'b1;
    end
    ana_addr_next   = ana_addr_reg;
    ana_retune_next = 1'b0;
    if (ana_fire) begin
      ana_addr_next   = addr_c;
      ana_retune_next = 1'b1;
    end else if (seq_fire && may_retune && analyzer_hop_mode && analyzer_trigger_armed) begin
      ana_addr_next   = seq_addr_next;
      ana_retune_next = 1'b1;
    end
  end

  // burst type, demod trigger and counter halt
  always_comb begin
    burst_pins  = {ctrl_c[`BURST_MSB_OFS], ctrl_c[`BURST_LSB_OFS]};
    dburst_next = dburst_reg;
    mburst_next = mburst_reg;
    if (burst_start) begin
      dburst_next = demod_burst_external ? burst_pins : demod_burst_internal;
      mburst_next = meas_burst_external ? burst_pins : meas_burst_internal;
    end
    dstart_next   = rise[`DEMOD_TRIG_OFS] && demod_trigger_external;
    mstart_next   = rise[`DEMOD_TRIG_OFS] && meas_trigger_external;
    hold_next     = !ctrl_c[`CNT_RST_N_OFS];
    // settable mode forces the status low whatever the pin does
    status_n_next = settable_mode ? 1'b0 : ctrl_c[`CNT_RST_N_OFS];
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      prev_reg       <= `CTRL_IDLE;
      gen_addr_reg   <= '0;
      ana_addr_reg   <= '0;
      seq_addr_reg   <= '0;
      gen_retune_reg <= 1'b0;
      ana_retune_reg <= 1'b0;
      dburst_reg     <= `BURST_RESET;
      mburst_reg     <= `BURST_RESET;
      dstart_reg     <= 1'b0;
      mstart_reg     <= 1'b0;
      hold_reg       <= 1'b0;
      status_n_reg   <= 1'b1;
    end else begin
      prev_reg       <= prev_next;
      gen_addr_reg   <= gen_addr_next;
      ana_addr_reg   <= ana_addr_next;
      seq_addr_reg   <= seq_addr_next;
      gen_retune_reg <= gen_retune_next;
      ana_retune_reg <= ana_retune_next;
      dburst_reg     <= dburst_next;
      mburst_reg     <= mburst_next;
      dstart_reg     <= dstart_next;
      mstart_reg     <= mstart_next;
      hold_reg       <= hold_next;
      status_n_reg   <= status_n_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign generator_retune      = gen_retune_reg;
  assign generator_hop_address = gen_addr_reg;
  assign analyzer_retune       = ana_retune_reg;
  assign analyzer_hop_address  = ana_addr_reg;
  assign sequence_address      = seq_addr_reg;
  assign demod_burst_number    = dburst_reg;
  assign meas_burst_number     = mburst_reg;
  assign demod_start           = dstart_reg;
  assign meas_start            = mstart_reg;
  assign counter_hold          = hold_reg;
  assign counter_halt_status_n = status_n_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence seq_edge_reset;
    seq_fire && !ctrl_c[`SEQ_RST_N_OFS];
  endsequence
  sequence seq_edge_step;
    seq_fire && ctrl_c[`SEQ_RST_N_OFS];
  endsequence

  chk_gen_latch: assert property (gen_fire |=> generator_retune
    && generator_hop_address == $past(addr_c)) else $error("generator hop not latched");
  chk_ana_latch: assert property (ana_fire |=> analyzer_retune
    && analyzer_hop_address == $past(addr_c)) else $error("analyzer hop not latched");
  chk_seq_step: assert property (seq_edge_step |=>
    sequence_address == ADDR_W'($past(sequence_address) + 1'b1)) else $error("no seq step");
  chk_seq_reset: assert property (seq_edge_reset |=> sequence_address == $past(addr_c))
    else $error("sequence reset did not load address");
  chk_seq_hold: assert property (!seq_fire |=> $stable(sequence_address))
    else $error("sequence address moved without edge");
  chk_suppress_hop: assert property (seq_fire && !may_retune && !gen_fire |=>
    !generator_retune && $stable(generator_hop_address)) else $error("suppressed hop retuned");
  chk_demod_edge: assert property (rise[`DEMOD_TRIG_OFS] && demod_trigger_external
    |=> demod_start ##1 !demod_start) else $error("demod start not one pulse");
  chk_demod_gate: assert property (!demod_trigger_external |=> !demod_start)
    else $error("demod start without external source");
  chk_halt_mode: assert property (settable_mode |=> !counter_halt_status_n)
    else $error("halt status high in settable mode");
  chk_halt_follow: assert property (!settable_mode && !ctrl_c[`CNT_RST_N_OFS]
    |=> counter_hold && !counter_halt_status_n) else $error("counters not halted");
  chk_burst_decode: assert property (burst_start && demod_burst_external
    |=> demod_burst_number == {$past(ctrl_c[`BURST_MSB_OFS]), $past(ctrl_c[`BURST_LSB_OFS])})
    else $error("burst number misdecoded");
endmodule : ext_hop_trigger_control

/* File: rtl/pin_sync.sv */
// three-stage pin synchroniser with agreement filter
module pin_sync #(
  parameter int             W    = 20,
  parameter logic [W-1:0]   IDLE = '0
) (
  // clock and reset
  input  wire logic  clock,
  input  wire logic  rstn,
  // pins in, clean levels out
  pin_sync_if.sync   pins
);
  logic [W-1:0] s1_reg, s1_next;
  logic [W-1:0] s2_reg, s2_next;
  logic [W-1:0] s3_reg, s3_next;
  logic [W-1:0] clean_reg, clean_next;

  if (W < 1) begin : g_chk
    $error("pin_sync width must be at least one");
  end

  // stage one feeds only stage two; a bit changes once stages two and three agree
  always_comb begin
    s1_next    = pins.raw;
    s2_next    = s1_reg;
    s3_next    = s2_reg;
    clean_next = (s2_reg & s3_reg) | (clean_reg & (s2_reg | s3_reg));
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      s1_reg    <= IDLE;
      s2_reg    <= IDLE;
      s3_reg    <= IDLE;
      clean_reg <= IDLE;
    end else begin
      s1_reg    <= s1_next;
      s2_reg    <= s2_next;
      s3_reg    <= s3_next;
      clean_reg <= clean_next;
    end
  end

  assign pins.clean = clean_reg;
endmodule : pin_sync

/* File: rtl/pin_sync_if.sv */
// interface carrying raw pin levels into the synchroniser and clean levels out
interface pin_sync_if #(
  parameter int W = 20
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport sync (input raw, output clean);
  modport user (output raw, input clean);
endinterface : pin_sync_if

/* File: testbench/hop_partner.sv */
// model of the external hopping controller that drives the rear-panel pins
`include "ext_hop_regs.svh"
module hop_partner (
  // clock
  input  wire logic         clock,
  // pins: control levels above the eleven address lines
  output logic      [19:0]  pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // pin driving
  // ----------------------------------------------------------------
  initial pins = {`CTRL_IDLE, 11'h000};

  // six cycles per level: the synchroniser needs four, a slow controller gives more
  task automatic hold();
    repeat (6) @(posedge clock);
    #1;
  endtask

  // change one control level, address lines untouched
  task automatic level(input int ofs, input logic v);
    pins[11+ofs] = v;
    hold();
  endtask

  // rising then falling trigger around a stable binary address
  task automatic pulse(input int ofs, input logic [10:0] a);
    pins[10:0] = a;
    hold();
    level(ofs, 1'b1);
    level(ofs, 1'b0);
    // lines move on after the trigger, so late sampling shows up
    pins[10:0] = ~a;
    hold();
  endtask
endmodule // hop_partner

/* File: testbench/test_ext_hop_trigger_control.sv */
// self-checking bench for the rear-panel hop and trigger control block
`include "ext_hop_regs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module test_ext_hop_trigger_control;
  timeunit 1ns;
  timeprecision 1ps;
  import ext_hop_pkg::*;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic         clock = 1'b0;
  logic         rstn = 1'b0;
  logic [19:0]  pins;
  addr_source_t src = SRC_EXT;
  logic         gen_mode = 1'b0, gen_arm = 1'b0, ana_mode = 1'b0, ana_arm = 1'b0;
  logic         d_ext = 1'b0, m_ext = 1'b0, dt_ext = 1'b0, mt_ext = 1'b0;
  logic         bstart = 1'b0, settable = 1'b0;
  burst_num_t   d_int = '0, m_int = '0, d_num, m_num;
  logic         gen_rt, ana_rt, d_st, m_st, hold_o, halt_n;
  logic [10:0]  gen_a, ana_a, seq_a, a, s;
  logic [15:0]  exp_q[$];
  int           error_cnt = 0;
  int           check_count = 0;

  always #20 clock = ~clock;

  hop_partner u_partner (.clock(clock), .pins(pins));

  ext_hop_trigger_control u_dut (
    .clock(clock), .rstn(rstn), .hop_table_address(pins[10:0]),
    .generator_hop_trigger(pins[11]), .analyzer_hop_trigger(pins[12]),
    .sequence_hop_trigger(pins[13]), .sequence_address_reset_n(pins[14]),
    .hop_suppress_n(pins[15]), .counter_reset_in_n(pins[16]),
    .ext_demodulation_trigger(pins[17]), .burst_select_lsb(pins[18]),
    .burst_select_msb(pins[19]), .counter_halt_status_n(halt_n),
    .address_source(src), .generator_hop_mode(gen_mode), .generator_trigger_armed(gen_arm),
    .analyzer_hop_mode(ana_mode), .analyzer_trigger_armed(ana_arm),
    .demod_burst_external(d_ext), .meas_burst_external(m_ext),
    .demod_burst_internal(d_int), .meas_burst_internal(m_int),
    .demod_trigger_external(dt_ext), .meas_trigger_external(mt_ext),
    .burst_start(bstart), .settable_mode(settable),
    .generator_retune(gen_rt), .generator_hop_address(gen_a),
    .analyzer_retune(ana_rt), .analyzer_hop_address(ana_a), .sequence_address(seq_a),
    .demod_burst_number(d_num), .meas_burst_number(m_num),
    .demod_start(d_st), .meas_start(m_st), .counter_hold(hold_o));

  // ----------------------------------------------------------------
  // result watcher and bench tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // oldest note against each pulse; a pulse with no note is a fault
  task automatic take(input logic [15:0] got);
    logic [15:0] e;
    if (exp_q.size() == 0) begin
      error_cnt++;
      $display("[FAIL] %0t unexpected result %h", $time, got);
    end else begin
      e = exp_q.pop_front();
      `CHK(got, e)
    end
  endtask

  // pulses stand one cycle, so look half a cycle after each edge
  always @(negedge clock) begin
    if (rstn) begin
      // anything but a clean low counts as a pulse, so an unknown cannot hide
      if (gen_rt !== 1'b0) take({5'h01, gen_a});
      if (ana_rt !== 1'b0) take({5'h02, ana_a});
      if (d_st !== 1'b0) take({5'h03, 11'h000});
      if (m_st !== 1'b0) take({5'h04, 11'h000});
    end
  end

  // bounded drain of outstanding notes
  task automatic finish_test(input string name);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("[FAIL] %0t result missing in %s", $time, name);
      report_and_stop();
    end else begin
      $display("test %s done", name);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(47));
    repeat (4) @(posedge clock);
    #1;
    rstn = 1'b1;
    gen_mode = 1'b1;
    gen_arm = 1'b1;
    ana_mode = 1'b1;
    ana_arm = 1'b1;
    // external addressing, top address first
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 11'h7ff : 11'($urandom);
      exp_q.push_back({5'h01, a});
      u_partner.pulse(`GEN_TRIG_OFS, a);
      exp_q.push_back({5'h02, a});
      u_partner.pulse(`ANA_TRIG_OFS, a);
    end
    gen_arm = 1'b0;
    ana_mode = 1'b0;
    u_partner.pulse(`GEN_TRIG_OFS, 11'h155);
    u_partner.pulse(`ANA_TRIG_OFS, 11'h2aa);
    finish_test("external");
    // sequential: reset waits for a sequence edge, suppress stops retune only
    src = SRC_SEQ;
    gen_arm = 1'b1;
    u_partner.pulse(`GEN_TRIG_OFS, 11'h0f0);
    s = 11'($urandom);
    u_partner.level(`SEQ_RST_N_OFS, 1'b0);
    `CHK(seq_a, 11'h000)
    exp_q.push_back({5'h01, s});
    u_partner.pulse(`SEQ_TRIG_OFS, s);
    `CHK(seq_a, s)
    u_partner.level(`SEQ_RST_N_OFS, 1'b1);
    for (int i = 0; i < 3; i++) begin
      s = s + 11'h001;
      if (i == 2) u_partner.level(`SUPPRESS_N_OFS, 1'b0);
      else exp_q.push_back({5'h01, s});
      // one step also hops the analyzer, behind the generator note
      ana_mode = (i == 1);
      if (i == 1) exp_q.push_back({5'h02, s});
      u_partner.pulse(`SEQ_TRIG_OFS, 11'($urandom));
      `CHK(seq_a, s)
    end
    u_partner.level(`SUPPRESS_N_OFS, 1'b1);
    // nothing armed: sequence edges are refused and the register rests
    gen_arm = 1'b0;
    ana_arm = 1'b0;
    u_partner.pulse(`SEQ_TRIG_OFS, 11'h000);
    `CHK(seq_a, s)
    finish_test("sequential");
    // demod trigger under every source setting
    for (int i = 0; i < 4; i++) begin
      dt_ext = i[0];
      mt_ext = i[1];
      if (i[0]) exp_q.push_back({5'h03, 11'h000});
      if (i[1]) exp_q.push_back({5'h04, 11'h000});
      u_partner.pulse(`DEMOD_TRIG_OFS, 11'h000);
    end
    finish_test("demod trigger");
    // burst select, each code with each external setting
    for (int i = 0; i < 8; i++) begin
      d_ext = i[2];
      m_ext = ~i[2];
      d_int = 2'($urandom);
      m_int = 2'($urandom);
      u_partner.level(`BURST_LSB_OFS, i[0]);
      u_partner.level(`BURST_MSB_OFS, i[1]);
      bstart = 1'b1;
      @(posedge clock);
      #1;
      bstart = 1'b0;
      @(posedge clock);
      #1;
      `CHK(d_num, i[2] ? burst_num_t'(i[1:0]) : d_int)
      `CHK(m_num, i[2] ? m_int : burst_num_t'(i[1:0]))
    end
    $display("test burst select done");
    // counter halt and settable mode
    u_partner.level(`CNT_RST_N_OFS, 1'b0);
    `CHK(hold_o, 1'b1)
    `CHK(halt_n, 1'b0)
    u_partner.level(`CNT_RST_N_OFS, 1'b1);
    `CHK(hold_o, 1'b0)
    `CHK(halt_n, 1'b1)
    settable = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    `CHK(halt_n, 1'b0)
    finish_test("counter halt");
    report_and_stop();
  end
endmodule // test_ext_hop_trigger_control
